// >>> core/ccis_pkg.sv
// package: register map, field positions and reset values of the change-event status block
package ccis_pkg;
    // ------------------------------------------------------------
    // register byte offsets (apb, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] CCIS_OFF_ENABLE = 8'h00; // interrupt enable, read/write
    localparam logic [7:0] CCIS_OFF_EVENT = 8'h04; // change event status, clear on read
    localparam logic [7:0] CCIS_OFF_LEVEL = 8'h08; // live alarm levels, read only
    localparam logic [7:0] CCIS_OFF_CLEAR = 8'h0c; // write one to clear event bits
    // ------------------------------------------------------------
    // field positions, shared by all four registers
    // ------------------------------------------------------------
    localparam int CCIS_BIT_DRIVE_MON = 0; // drive_monitor_output
    localparam int CCIS_BIT_SIG_LOSS = 1; // loss_of_signal
    localparam int CCIS_BIT_LOCK_LOSS = 2; // loss_of_lock
    localparam int CCIS_BIT_FIFO_LIMIT = 3; // fifo_limit_alarm
    localparam int CCIS_NSRC = 4; // number of event sources
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [3:0] CCIS_RST_ENABLE = 4'h0;
    localparam logic [3:0] CCIS_RST_EVENT = 4'h0;
    localparam logic [31:0] CCIS_RDATA_ZERO = 32'h0000_0000;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef logic [CCIS_NSRC-1:0] ccis_vec_t; // one bit per source
endpackage

// >>> core/ccis_evt_if.sv
// interface: condition levels and change pulses between the detector and the register core
`timescale 1ns/1ps
interface ccis_evt_if;
    import ccis_pkg::*;
    ccis_vec_t level; // synchronised live levels
    ccis_vec_t change; // one-cycle change pulses
    modport det (output level, output change);
    modport core (input level, input change);
endinterface

// >>> core/ccis_edge.sv
// module: two-flop synchroniser and any-edge detector for the four condition inputs
`timescale 1ns/1ps
module ccis_edge
    import ccis_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire ccis_vec_t cond_async,
    ccis_evt_if.det evt
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        ccis_vec_t meta; // first flop, read only by sync
        ccis_vec_t sync; // second flop
        ccis_vec_t last; // previous synced level
    } ccis_edge_st_t;
    ccis_edge_st_t st_reg; // registered state
    ccis_edge_st_t st_next; // next state
    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.meta = cond_async;
        st_next.sync = st_reg.meta;
        st_next.last = st_reg.sync;
    end
    // registers; reset assumes all conditions idle low
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    // any edge counts
    // both declare and clear count as a change
    assign evt.change = st_reg.sync ^ st_reg.last;
    assign evt.level = st_reg.sync;
endmodule

// >>> core/ccis_top.sv
// module: apb slave with change-event status, alarm levels, enables and interrupt
//
// How it works
// - bit 3 latches fifo_limit_alarm changes
// - bit 2 latches loss_of_lock changes
// - bit 1 latches loss_of_signal changes
// - bit 0 latches drive_monitor_output changes
// - read returns events, then clears; 31:4 zero
// - level register shows live conditions
// - declare and clear both are events
// - enable bit gates source onto interrupt
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module ccis_top
    import ccis_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fifo_limit_alarm,
    input wire logic loss_of_lock,
    input wire logic loss_of_signal,
    input wire logic drive_monitor_output,
    output logic irq
);
    // ------------------------------------------------------------
    // condition detector
    // ------------------------------------------------------------
    // levels and change pulses from the detector
    ccis_evt_if evt ();
    ccis_vec_t cond_raw; // raw pin levels
    // bit order matches every register field
    assign cond_raw = {fifo_limit_alarm, loss_of_lock, loss_of_signal, drive_monitor_output};
    // two sync flops plus the edge flop: an event lands three edges after the pin
    ccis_edge ccis_edge_i (
        .clock(clock),
        .rst(rst),
        .cond_async(cond_raw),
        .evt(evt)
    );
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // one packed struct keeps all state in one register
    typedef struct packed {
        ccis_vec_t event_bits; // sticky change events
        ccis_vec_t enable_bits; // interrupt enables
        logic [31:0] rdata; // registered read data
        logic irq; // registered interrupt
    } ccis_st_t;
    ccis_st_t st_reg; // registered state
    ccis_st_t st_next; // next state
    logic access; // apb access phase, always zero wait
    logic known; // address decodes
    ccis_vec_t clr_mask; // bits cleared this cycle
    // pready is tied high, so every access phase lasts one cycle
    assign access = psel & penable;
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // address decode, used only for the error response
    always_comb begin
        unique case (paddr)
            // the four mapped words
            CCIS_OFF_ENABLE, CCIS_OFF_EVENT, CCIS_OFF_LEVEL, CCIS_OFF_CLEAR: begin
                known = 1'b1;
            end
            // anything else answers with pslverr and has no effect
            default: begin
                known = 1'b0;
            end
        endcase
    end
    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // events, enables, read data and interrupt, all from one copy
    always_comb begin
        st_next = st_reg;
        clr_mask = '0;
        if (access && !pwrite && paddr == CCIS_OFF_EVENT) begin
            clr_mask = '1;
        end
        // explicit clear register, write one to clear
        if (access && pwrite && paddr == CCIS_OFF_CLEAR) begin
            clr_mask = pwdata[CCIS_NSRC-1:0];
        end
        st_next.event_bits = (st_reg.event_bits & ~clr_mask) | evt.change;
        // enable register write
        if (access && pwrite && paddr == CCIS_OFF_ENABLE) begin
            st_next.enable_bits = pwdata[CCIS_NSRC-1:0];
        end
        // read data, captured at the setup edge; reserved bits zero
        st_next.rdata = CCIS_RDATA_ZERO;
        // captured in setup so it stands through the access phase
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                // enable register read back
                CCIS_OFF_ENABLE: begin
                    st_next.rdata[CCIS_NSRC-1:0] = st_reg.enable_bits;
                end
                CCIS_OFF_EVENT: begin
                    st_next.rdata[CCIS_NSRC-1:0] = st_reg.event_bits | evt.change;
                end
                CCIS_OFF_LEVEL: begin
                    st_next.rdata[CCIS_NSRC-1:0] = evt.level;
                end
                // clear register and unmapped words read zero
                default: begin
                    st_next.rdata = CCIS_RDATA_ZERO;
                end
            endcase
        end
        st_next.irq = |(st_next.event_bits & st_next.enable_bits);
    end
    // registers
    // reset: no events, every source masked, bus quiet
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_reg.event_bits <= CCIS_RST_EVENT;
            st_reg.enable_bits <= CCIS_RST_ENABLE;
            st_reg.rdata <= CCIS_RDATA_ZERO;
            st_reg.irq <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end
    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata = st_reg.rdata; // sampled during setup, stable in access
    // zero wait states; the price is read data fixed at the setup edge
    assign pready = 1'b1;
    assign pslverr = access & ~known; // unmapped address errors
    assign irq = st_reg.irq;
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // all properties run on the bus clock and stop during reset
    // fifo limit latched
    property p_fifo_limit_latch;
        @(posedge clock) disable iff (rst)
        evt.change[CCIS_BIT_FIFO_LIMIT] |=> st_reg.event_bits[CCIS_BIT_FIFO_LIMIT];
    endproperty
    a_fifo_limit_latch: assert property (p_fifo_limit_latch)
        else $error("fifo limit change not latched");
    property p_lock_loss_latch;
        @(posedge clock) disable iff (rst)
        evt.change[CCIS_BIT_LOCK_LOSS] |=> st_reg.event_bits[CCIS_BIT_LOCK_LOSS];
    endproperty
    a_lock_loss_latch: assert property (p_lock_loss_latch)
        else $error("lock loss change not latched");
    property p_sig_loss_latch;
        @(posedge clock) disable iff (rst)
        evt.change[CCIS_BIT_SIG_LOSS] |=> st_reg.event_bits[CCIS_BIT_SIG_LOSS];
    endproperty
    a_sig_loss_latch: assert property (p_sig_loss_latch)
        else $error("signal loss change not latched");
    property p_drive_mon_latch;
        @(posedge clock) disable iff (rst)
        evt.change[CCIS_BIT_DRIVE_MON] |=> st_reg.event_bits[CCIS_BIT_DRIVE_MON];
    endproperty
    a_drive_mon_latch: assert property (p_drive_mon_latch)
        else $error("drive monitor change not latched");
    // no event without change; a sticky bit only rises on a pulse
    property p_no_spurious;
        @(posedge clock) disable iff (rst)
        1'b1
            |=> (st_reg.event_bits & ~$past(st_reg.event_bits) & ~$past(evt.change)) == '0;
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("event bit set without a change");
    property p_read_clear;
        @(posedge clock) disable iff (rst)
        (access && !pwrite && paddr == CCIS_OFF_EVENT && evt.change == '0)
            |=> st_reg.event_bits == '0;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("read did not clear");
    property p_rsv_zero;
        @(posedge clock) disable iff (rst)
        prdata[31:CCIS_NSRC] == '0;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero)
        else $error("reserved read bits not zero");
    property p_level;
        @(posedge clock) disable iff (rst)
        (psel && !penable && !pwrite && paddr == CCIS_OFF_LEVEL)
            |=> prdata[CCIS_NSRC-1:0] == $past(evt.level) && prdata[31:CCIS_NSRC] == '0;
    endproperty
    a_level: assert property (p_level)
        else $error("level read wrong");
    // declare and clear both leave a sticky bit
    property p_edge_event;
        @(posedge clock) disable iff (rst)
        $changed(evt.level)
            |=> (st_reg.event_bits & ($past(evt.level) ^ $past(evt.level, 2)))
            == ($past(evt.level) ^ $past(evt.level, 2));
    endproperty
    a_edge_event: assert property (p_edge_event)
        else $error("level edge not latched");
    property p_enable_write;
        @(posedge clock) disable iff (rst)
        (access && pwrite && paddr == CCIS_OFF_ENABLE)
            |=> st_reg.enable_bits == $past(pwdata[CCIS_NSRC-1:0]);
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("enable write not taken");
    property p_irq;
        @(posedge clock) disable iff (rst)
        irq == |(st_reg.event_bits & st_reg.enable_bits);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not gated by enables");
    // change racing a clearing read survives
    property p_keep;
        @(posedge clock) disable iff (rst)
        (access && !pwrite && paddr == CCIS_OFF_EVENT && evt.change != '0)
            |=> (st_reg.event_bits & $past(evt.change)) == $past(evt.change);
    endproperty
    a_keep: assert property (p_keep)
        else $error("event lost at clearing read");
endmodule

// >>> tb/ccis_bench.sv
// testbench: apb-driven self-checking bench for the change-event status block
`timescale 1ns/1ps
module channel_change_interrupt_status_bench;
    import ccis_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clock, rst, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] cond; // driven levels, bit order as the register fields
    logic [3:0] prev; // levels seen at the last clearing read
    logic [7:0] lfsr_reg; // random source
    logic [32:0] exp_q[$]; // notes of {pslverr, prdata} per read
    int num_errors, n_compared, cycles;

    ccis_top ccis_top_i (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fifo_limit_alarm(cond[CCIS_BIT_FIFO_LIMIT]),
        .loss_of_lock(cond[CCIS_BIT_LOCK_LOSS]), .loss_of_signal(cond[CCIS_BIT_SIG_LOSS]),
        .drive_monitor_output(cond[CCIS_BIT_DRIVE_MON]), .irq(irq));

    // ------------------------------------------------------------
    // clock, timeout, helpers
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // a hang counts as a mismatch; the full run needs well under 1000 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    function automatic logic [7:0] lfsr_step(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic tally_and_finish();
        if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
        exp_q.push_back({e, d});
        apb(1'b0, a, 32'h0000_0000);
    endtask
    // conditions change just after an edge, then the synchroniser gets time
    task automatic chg(input logic [3:0] v);
        @(posedge clock);
        cond <= v;
    endtask
    task automatic settle();
        repeat (5) @(posedge clock);
    endtask
    task automatic check_irq(input logic e);
        n_compared++;
        if (irq !== e) begin
            num_errors++;
            $display("[FAIL] %0t irq got %h exp %h", $time, irq, e);
        end
    endtask
    task automatic check_rd(input logic [32:0] e);
        n_compared++;
        if ({pslverr, prdata} !== e) begin
            num_errors++;
            $display("[FAIL] %0t read got %h exp %h", $time, {pslverr, prdata}, e);
        end
    endtask
    // watcher: every completed read takes the oldest note
    always @(posedge clock) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            check_rd(exp_q.pop_front());
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        cond = 4'h0;
        lfsr_reg = 8'h5b;
        num_errors = 0;
        n_compared = 0;
        cycles = 0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        rd(CCIS_OFF_ENABLE, 32'h0, 1'b0);
        rd(CCIS_OFF_EVENT, 32'h0, 1'b0);
        rd(CCIS_OFF_LEVEL, 32'h0, 1'b0);
        // each source alone, one at a time
        for (int b = 0; b < 4; b++) begin
            chg(cond ^ (4'h1 << b));
            settle();
            rd(CCIS_OFF_EVENT, 32'h1 << b, 1'b0);
        end
        prev = cond;
        // random declare and clear patterns
        for (int i = 0; i < 12; i++) begin
            lfsr_reg = lfsr_step(lfsr_reg);
            chg(lfsr_reg[3:0]);
            settle();
            rd(CCIS_OFF_LEVEL, {28'h0, lfsr_reg[3:0]}, 1'b0);
            rd(CCIS_OFF_EVENT, {28'h0, lfsr_reg[3:0] ^ prev}, 1'b0);
            rd(CCIS_OFF_EVENT, 32'h0, 1'b0);
            prev = lfsr_reg[3:0];
        end
        // interrupt: only drive_monitor_output enabled, upper bits ignored
        apb(1'b1, CCIS_OFF_ENABLE, 32'hffff_fff1);
        rd(CCIS_OFF_ENABLE, 32'h1, 1'b0);
        chg(cond ^ 4'h2);
        settle();
        check_irq(1'b0);
        chg(cond ^ 4'h1);
        settle();
        check_irq(1'b1);
        rd(CCIS_OFF_EVENT, 32'h3, 1'b0);
        repeat (2) @(posedge clock);
        check_irq(1'b0);
        chg(cond ^ 4'h1);
        settle();
        check_irq(1'b1);
        apb(1'b1, CCIS_OFF_CLEAR, 32'h0000_0001);
        repeat (2) @(posedge clock);
        check_irq(1'b0);
        rd(CCIS_OFF_EVENT, 32'h0, 1'b0);
        // read-only level, unmapped place, clear register reads zero
        apb(1'b1, CCIS_OFF_LEVEL, 32'h0000_000f);
        rd(CCIS_OFF_LEVEL, {28'h0, cond}, 1'b0);
        rd(8'h10, 32'h0, 1'b1);
        rd(CCIS_OFF_CLEAR, 32'h0, 1'b0);
        // change lands on the clearing edge of a read and must survive it
        chg(cond ^ 4'h8);
        rd(CCIS_OFF_EVENT, 32'h0, 1'b0);
        rd(CCIS_OFF_EVENT, 32'h8, 1'b0);
        repeat (3) @(posedge clock);
        tally_and_finish();
    end
endmodule
